// >>> verilog/eep_defs.svh
// constants for the two-wire serial memory target
// assumes a 50 MHz core clock; included by bare name
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH

`define EEP_BYTE_BITS    4'h8
`define EEP_LAST_BIT     4'h7
`define EEP_ADDR_W       8
`define EEP_MEM_DEPTH    256
`define EEP_MULTI_MAX    4'h4
`define EEP_PAGE_MAX     4'h8
`define EEP_ROW_MSB      7
`define EEP_ROW_LSB      3
`define EEP_DS_TYPE_MSB  7
`define EEP_DS_TYPE_LSB  4
`define EEP_DS_CE_MSB    3
`define EEP_DS_CE_LSB    1
`define EEP_DS_RW        0
`define EEP_FIFO_DEPTH   16
`define EEP_TW_MS        32'h0000_000A
`define EEP_TW_LONG_MS   32'h0000_0014
`define EEP_CLK_KHZ      32'h0000_C350

`endif

// >>> verilog/eep_pkg.sv
// types shared by the serial memory target
// assumes nothing beyond a SystemVerilog elaborator
package eep_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RX     = 5'b00010,
    ST_RX_ACK = 5'b00100,
    ST_TX     = 5'b01000,
    ST_TX_ACK = 5'b10000
  } eep_state_e;

  typedef enum logic [2:0] {
    PH_DEV  = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } eep_phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } eep_pins_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } eep_wr_s;

endpackage

// >>> verilog/eep_sync.sv
// two-flop synchroniser for pin levels
// assumes inputs asynchronous to clk
module eep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> verilog/eep_fifo.sv
// write-data buffer with valid/ready on both sides
// assumes one clock; depth a power of two
module eep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty_w = (wr_ptr_reg == rd_ptr_reg);
  wire              push_w  = in_valid && !full_w;
  wire              pop_w   = out_ready && !empty_w;

  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = buf_mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push_w) begin
      buf_mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push_w);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop_w);
    end
  end

endmodule

// >>> verilog/eep_target.sv
// two-wire serial memory target: 256 x 8 array, writes, reads, write cycle
// assumes the bus clock is slow against clk and both pins pulled up outside
`include "eep_defs.svh"

module eep_target #(
  parameter logic [3:0] DEV_TYPE       = 4'h5, // arbitrary type code
  parameter int         TW_CYCLES      = `EEP_TW_MS * `EEP_CLK_KHZ,
  parameter int         TW_LONG_CYCLES = `EEP_TW_LONG_MS * `EEP_CLK_KHZ,
  parameter int         FIFO_DEPTH     = `EEP_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic [2:0] chip_select_strap_pins,
  input  wire logic       write_mode_pin,
  output logic            write_busy
);

  localparam int TMR_W = $clog2(TW_LONG_CYCLES + 1);
  localparam int WR_W  = $bits(eep_pkg::eep_wr_s);

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling and line events

  eep_pkg::eep_pins_s pins_s;
  eep_pkg::eep_pins_s pins_prev_reg;
  logic [2:0]         strap_s;
  logic               mode_s;

  eep_sync #(.W(6)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({scl_in, sda_in, chip_select_strap_pins, write_mode_pin}),
    .sync_out ({pins_s, strap_s, mode_s})
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      pins_prev_reg <= '1;
    end else begin
      pins_prev_reg <= pins_s;
    end
  end

  wire scl_rise  = pins_s.scl && !pins_prev_reg.scl;
  wire scl_fall  = !pins_s.scl && pins_prev_reg.scl;
  wire scl_hold  = pins_s.scl && pins_prev_reg.scl;
  wire start_det = scl_hold && pins_prev_reg.sda && !pins_s.sda;
  wire stop_det  = scl_hold && !pins_prev_reg.sda && pins_s.sda;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  eep_pkg::eep_state_e state_reg, state_next;
  eep_pkg::eep_phase_e phase_reg, phase_next;
  logic [3:0]          bit_cnt_reg, bit_cnt_next;
  logic [7:0]          shift_reg, shift_next;
  logic [7:0]          addr_reg, addr_next;
  logic                rw_reg, rw_next;
  logic                mack_reg, mack_next;
  logic                oe_n_next;
  logic [3:0]          wr_count_reg, wr_count_next;
  logic [4:0]          first_row_reg, first_row_next;
  logic                span_reg, span_next;
  logic                busy_next;
  logic [TMR_W-1:0]    timer_reg, timer_next;

  logic [7:0]          mem [`EEP_MEM_DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic [7:0] addr_inc(input logic [7:0] a);
    addr_inc = a + 8'h01;
  endfunction

  wire [7:0] mem_rd    = mem[addr_reg];
  wire       byte_done = (bit_cnt_reg == `EEP_BYTE_BITS);
  wire       rx_end    = (state_reg == eep_pkg::ST_RX) && scl_fall && byte_done;
  wire       dev_match = (shift_reg[`EEP_DS_TYPE_MSB:`EEP_DS_TYPE_LSB] == DEV_TYPE) &&
                         (shift_reg[`EEP_DS_CE_MSB:`EEP_DS_CE_LSB] == strap_s);
  wire [3:0] wr_limit  = mode_s ? `EEP_MULTI_MAX : `EEP_PAGE_MAX;
  wire       fifo_in_ready;
  wire       push_ok   = (wr_count_reg < wr_limit) && fifo_in_ready;
  wire       push_w    = rx_end && (phase_reg == eep_pkg::PH_DATA) && push_ok;
  wire [4:0] row_now   = addr_reg[`EEP_ROW_MSB:`EEP_ROW_LSB];
  wire       launch_w  = stop_det && (wr_count_reg != 4'h0) && !write_busy;
  wire       fifo_out_valid;
  eep_pkg::eep_wr_s fifo_in_w;
  eep_pkg::eep_wr_s fifo_out_w;

  assign fifo_in_w = '{addr: addr_reg, data: shift_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // write buffer, drained only during the write cycle

  eep_fifo #(.WIDTH(WR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push_w),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_w),
    .out_valid (fifo_out_valid),
    .out_ready (write_busy),
    .out_data  (fifo_out_w)
  );

  always_ff @(posedge clk) begin
    if (write_busy && fifo_out_valid) begin
      mem[fifo_out_w.addr] <= fifo_out_w.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protocol next state

  always_comb begin
    state_next     = state_reg;
    phase_next     = phase_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    addr_next      = addr_reg;
    rw_next        = rw_reg;
    mack_next      = mack_reg;
    oe_n_next      = sda_oe_n;
    wr_count_next  = wr_count_reg;
    first_row_next = first_row_reg;
    span_next      = span_reg;
    if (stop_det) begin
      state_next = eep_pkg::ST_IDLE;
      oe_n_next  = 1'b1;
    end else if (start_det) begin
      state_next   = eep_pkg::ST_RX;
      phase_next   = eep_pkg::PH_DEV;
      bit_cnt_next = 4'h0;
      oe_n_next    = 1'b1;
    end else begin
      case (state_reg)
        eep_pkg::ST_IDLE: begin
          oe_n_next = 1'b1;
        end
        eep_pkg::ST_RX: begin
          if (scl_rise && !byte_done) begin
            shift_next   = {shift_reg[6:0], pins_s.sda};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (rx_end) begin
            state_next = eep_pkg::ST_RX_ACK;
            oe_n_next  = 1'b0;
            case (phase_reg)
              eep_pkg::PH_DEV: begin
                rw_next = shift_reg[`EEP_DS_RW];
                if (!dev_match || write_busy) begin
                  state_next = eep_pkg::ST_IDLE;
                  oe_n_next  = 1'b1;
                end
              end
              eep_pkg::PH_ADDR: begin
                addr_next = shift_reg;
              end
              eep_pkg::PH_DATA: begin
                if (push_ok) begin
                  addr_next     = addr_inc(addr_reg);
                  wr_count_next = wr_count_reg + 4'h1;
                  if (wr_count_reg == 4'h0) begin
                    first_row_next = row_now;
                  end else if (row_now != first_row_reg) begin
                    span_next = 1'b1;
                  end
                end else begin
                  state_next = eep_pkg::ST_IDLE;
                  oe_n_next  = 1'b1;
                end
              end
              default: begin
                state_next = eep_pkg::ST_IDLE;
                oe_n_next  = 1'b1;
              end
            endcase
          end
        end
        eep_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (phase_reg == eep_pkg::PH_DEV && rw_reg) begin
              state_next = eep_pkg::ST_TX;
              shift_next = mem_rd;
              addr_next  = addr_inc(addr_reg);
              oe_n_next  = mem_rd[7];
            end else begin
              state_next = eep_pkg::ST_RX;
              oe_n_next  = 1'b1;
              phase_next = (phase_reg == eep_pkg::PH_DEV) ? eep_pkg::PH_ADDR
                                                          : eep_pkg::PH_DATA;
            end
          end
        end
        eep_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `EEP_LAST_BIT) begin
              state_next = eep_pkg::ST_TX_ACK;
              oe_n_next  = 1'b1;
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              oe_n_next    = shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        eep_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            mack_next = !pins_s.sda;
          end else if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (mack_reg) begin
              state_next = eep_pkg::ST_TX;
              shift_next = mem_rd;
              addr_next  = addr_inc(addr_reg);
              oe_n_next  = mem_rd[7];
            end else begin
              state_next = eep_pkg::ST_IDLE;
              oe_n_next  = 1'b1;
            end
          end
        end
        default: begin
          state_next = eep_pkg::ST_IDLE;
          oe_n_next  = 1'b1;
        end
      endcase
    end
    if (launch_w) begin
      wr_count_next = 4'h0;
      span_next     = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // internal write cycle timing

  always_comb begin
    busy_next  = write_busy;
    timer_next = timer_reg;
    if (launch_w) begin
      busy_next  = 1'b1;
      timer_next = (span_reg && mode_s) ? TMR_W'(TW_LONG_CYCLES)
                                        : TMR_W'(TW_CYCLES);
    end else if (write_busy) begin
      if (timer_reg != '0) begin
        timer_next = timer_reg - TMR_W'(1);
      end else if (!fifo_out_valid) begin
        busy_next = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= eep_pkg::ST_IDLE;
      phase_reg     <= eep_pkg::PH_DEV;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      addr_reg      <= 8'h00;
      rw_reg        <= 1'b0;
      mack_reg      <= 1'b0;
      sda_oe_n      <= 1'b1;
      sda_out       <= 1'b0;
      wr_count_reg  <= 4'h0;
      first_row_reg <= 5'h00;
      span_reg      <= 1'b0;
      write_busy    <= 1'b0;
      timer_reg     <= '0;
    end else begin
      state_reg     <= state_next;
      phase_reg     <= phase_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      addr_reg      <= addr_next;
      rw_reg        <= rw_next;
      mack_reg      <= mack_next;
      sda_oe_n      <= oe_n_next;
      sda_out       <= 1'b0;
      wr_count_reg  <= wr_count_next;
      first_row_reg <= first_row_next;
      span_reg      <= span_next;
      write_busy    <= busy_next;
      timer_reg     <= timer_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence dev_byte_end;
    rx_end && phase_reg == eep_pkg::PH_DEV && !start_det && !stop_det;
  endsequence

  sequence ack_slot_end;
    state_reg == eep_pkg::ST_RX_ACK && scl_fall && !start_det && !stop_det;
  endsequence

  busy_nak_a: assert property (dev_byte_end ##0 write_busy |=>
    state_reg == eep_pkg::ST_IDLE && sda_oe_n)
    else $error("select byte acknowledged during write cycle");

  select_match_a: assert property (dev_byte_end ##0 !write_busy |=>
    (state_reg == eep_pkg::ST_RX_ACK) == $past(dev_match))
    else $error("select acknowledge disagrees with strap match");

  ack_drive_a: assert property (state_reg == eep_pkg::ST_RX_ACK |->
    !sda_oe_n)
    else $error("acknowledge slot without data pulled low");

  idle_release_a: assert property (state_reg == eep_pkg::ST_IDLE |->
    sda_oe_n)
    else $error("data driven while idle");

  msb_order_a: assert property (state_reg == eep_pkg::ST_TX && scl_fall &&
    bit_cnt_reg < `EEP_LAST_BIT && !start_det && !stop_det |=>
    sda_oe_n == $past(shift_reg[6]))
    else $error("transmit bit order broken");

  ack_flow_a: assert property (ack_slot_end ##0 !rw_reg |=>
    state_reg == eep_pkg::ST_RX && bit_cnt_reg == 4'h0 && sda_oe_n)
    else $error("acknowledge slot did not return to receive");

  addr_step_a: assert property (push_w |=>
    addr_reg == $past(addr_reg) + 8'h01 && wr_count_reg == $past(wr_count_reg) + 4'h1)
    else $error("address counter did not advance on write byte");

  write_limit_a: assert property (rx_end && phase_reg == eep_pkg::PH_DATA &&
    wr_count_reg >= wr_limit |-> !push_w ##1 state_reg == eep_pkg::ST_IDLE && sda_oe_n)
    else $error("more write bytes taken than the mode allows");

  seq_read_a: assert property (state_reg == eep_pkg::ST_TX_ACK && scl_fall &&
    mack_reg && !start_det && !stop_det |=>
    state_reg == eep_pkg::ST_TX ##0 shift_reg == $past(mem_rd))
    else $error("acknowledged read did not continue");

  write_time_a: assert property ($rose(write_busy) |->
    timer_reg == ($past(span_reg && mode_s) ? TMR_W'(TW_LONG_CYCLES) : TMR_W'(TW_CYCLES)))
    else $error("write cycle loaded with wrong duration");

  busy_end_a: assert property (write_busy && timer_reg == '0 &&
    !fifo_out_valid && !launch_w |=> !write_busy)
    else $error("write cycle overran its time");

  start_seen_a: assert property (start_det && !stop_det |=>
    state_reg == eep_pkg::ST_RX && phase_reg == eep_pkg::PH_DEV && bit_cnt_reg == 4'h0)
    else $error("start condition not taken");

endmodule

// >>> bench/eep_master_model.sv
// two-wire bus master model: bus clock, start, stop, byte slots
// assumes the data wire is resolved outside it with a pull-up
module eep_master_model #(
  parameter int Q = 100
) (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_m   = 1'b1;
    sda_rel = 1'b1;
  end

  // quarter of a bus clock period, so each phase lasts 2 x Q clk
  task automatic tick;
    repeat (Q) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bit_io(input logic b, output logic r);
    tick();
    sda_rel <= b;
    tick();
    scl_m <= 1'b1;
    tick();
    r = sda_w;
    tick();
    scl_m <= 1'b0;
  endtask

  task automatic start;
    tick();
    sda_rel <= 1'b1;
    tick();
    scl_m <= 1'b1;
    tick();
    sda_rel <= 1'b0;
    tick();
    scl_m <= 1'b0;
  endtask

  task automatic stop;
    tick();
    sda_rel <= 1'b0;
    tick();
    scl_m <= 1'b1;
    tick();
    sda_rel <= 1'b1;
    tick();
  endtask

  // eight bits then the acknowledge slot; released data reads back as sent
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_out, ack_in);
  endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the serial memory target and its write buffer
// assumes eep_pkg and the design files compiled first, master model beside
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TYPE = 4'h5; // arbitrary type code
  localparam int         TW   = 8000;
  localparam int         TWL  = 16000;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       wmode = 1'b0;
  logic [2:0] straps = 3'h5;
  logic       scl_m, sda_rel, sda_out, sda_oe_n, write_busy;
  logic [7:0] model [256];
  logic [7:0] cur_addr;
  int         busy_cnt = 0;
  int         busy_len = 0;
  int         failures = 0;
  int         checks_done = 0;
  wire        sda_w = sda_rel & (sda_oe_n | sda_out);

  // bus clock period 4 x Q clk, 160 ns
  eep_master_model #(.Q(2)) mst_u (.clk(clk), .sda_w(sda_w), .scl_m(scl_m),
    .sda_rel(sda_rel));
  eep_target #(.DEV_TYPE(TYPE), .TW_CYCLES(TW), .TW_LONG_CYCLES(TWL), .FIFO_DEPTH(16)) dut_u (
    .clk(clk), .srst(srst), .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_select_strap_pins(straps), .write_mode_pin(wmode),
    .write_busy(write_busy));

  initial begin
    forever #10 clk = ~clk;
  end

  // length of the last busy period, in clk cycles
  always @(posedge clk) begin
    busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    if (!write_busy && busy_cnt != 0) busy_len <= busy_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sel(input logic rw, input logic [2:0] ce, input logic ok);
    logic [7:0] r;
    logic       a;
    mst_u.start();
    mst_u.xfer({TYPE, ce, rw}, 1'b1, r, a);
    check(a, !ok);
  endtask

  task automatic wr(input logic [7:0] a, input int n, input int good, input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    sel(1'b0, straps, 1'b1);
    mst_u.xfer(a, 1'b1, r, k);
    check(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      mst_u.xfer(d + 8'(i), 1'b1, r, k);
      check(k, i >= good);
      if (i < good) model[a + 8'(i)] = d + 8'(i);
    end
    mst_u.stop();
    repeat (10) @(posedge clk);
    check(write_busy, 1'b1);
  endtask

  task automatic wait_idle(input int lo, input int hi);
    int t;
    for (t = 0; t < 20000 && write_busy !== 1'b0; t++) @(posedge clk);
    if (t == 20000) begin
      failures++;
      summarize();
    end else begin
      repeat (2) @(posedge clk);
      check(busy_len >= lo && busy_len <= hi, 1'b1);
      check(write_busy, 1'b0);
    end
  endtask

  task automatic rd(input logic rnd, input logic [7:0] a, input int n);
    logic [7:0] r;
    logic       k;
    if (rnd) begin
      sel(1'b0, straps, 1'b1);
      mst_u.xfer(a, 1'b1, r, k);
      check(k, 1'b0);
      cur_addr = a;
    end
    sel(1'b1, straps, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst_u.xfer(8'hFF, i == n - 1, r, k);
      check(r, model[cur_addr]);
      cur_addr++;
    end
    mst_u.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_strap;
    sel(1'b0, 3'h3, 1'b0);
    mst_u.stop();
  endtask

  // page mode: eight bytes in one row, a ninth refused, select refused while busy
  task automatic t_page;
    wmode <= 1'b0;
    wr(8'h40, 9, 8, 8'h31);
    sel(1'b0, straps, 1'b0);
    mst_u.stop();
    wait_idle(TW - 2, TW + 12);
  endtask

  task automatic t_reads;
    rd(1'b1, 8'h40, 7);
    rd(1'b0, 8'h00, 1);
  endtask

  // multibyte mode across two rows: four bytes, fifth refused, long write time
  task automatic t_multi;
    wmode <= 1'b1;
    wr(8'h46, 5, 4, 8'hA7);
    wait_idle(TWL - 2, TWL + 12);
    rd(1'b1, 8'h45, 5);
  endtask

  // byte write in multibyte mode: one byte through the write buffer, short write time
  task automatic t_byte;
    wr(8'h10, 1, 1, 8'h5C);
    sel(1'b1, straps, 1'b0);
    mst_u.stop();
    check(sda_oe_n, 1'b1);
    wait_idle(TW - 2, TW + 12);
    rd(1'b1, 8'h10, 1);
    check(sda_oe_n, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    check(sda_oe_n, 1'b1);
    check(write_busy, 1'b0);
    check(sda_out, 1'b0);
    t_strap();
    t_page();
    t_reads();
    t_multi();
    t_byte();
    summarize();
  end
endmodule
